// ---- bench/alc_media_model.sv ----
/*
 * Media-side model for the long read/write path of the command engine.
 * Assumes single-cycle request pulses on the core clock.
 */
`timescale 1ns/1ps
module alc_media_model
	import alc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic media_rd_req,
	input wire logic media_rd_ready,
	output logic media_rd_valid,
	output logic [15:0] media_rd_data,
	input wire logic media_wr_valid,
	output logic media_wr_ready,
	output int wr_count
);
	int left = 0;
	initial begin
		media_rd_valid = 1'b0;
		media_rd_data = 16'h0000;
		media_wr_ready = 1'b0;
		wr_count = 0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one raw sector plus ecc per request; idle data toggles so stale words never match
	always @(posedge sys_clk) begin
		if (media_rd_req) begin
			left <= int'(LONG_WORDS);
			media_rd_valid <= 1'b1;
		end else if (media_rd_valid && media_rd_ready) begin
			left <= left - 1;
			media_rd_valid <= (left > 1);
			media_rd_data <= media_rd_data + 16'h0001;
		end else if (!media_rd_valid) begin
			media_rd_data <= ~media_rd_data;
		end
		// sink stalls every other cycle to exercise write backpressure
		media_wr_ready <= ~media_wr_ready;
		if (media_wr_valid && media_wr_ready) begin
			wr_count <= wr_count + 1;
		end
	end
endmodule // alc_media_model

// ---- bench/ata_max_lock_diag_long_cmds_tb_top.sv ----
/*
 * Self-checking bench for the command engine.
 * Assumes the media model and a pulled-up pass line shared with device 1.
 */
`timescale 1ns/1ps
module ata_max_lock_diag_long_cmds_tb_top;
	import alc_pkg::*;
	localparam int unsigned WAIT_CYC = 20;
	logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, host_wr_valid = 1'b0, media_err = 1'b0;
	logic host_rd_ready = 1'b1, is_device1 = 1'b0, device1_present = 1'b0, dev1_pass_n = 1'b1;
	logic [7:0] cmd_opcode = 8'h00, features_reg = 8'h00, device_head_reg = 8'h00;
	logic [7:0] sector_count_reg = 8'h01, sector_number_reg = 8'h00, cylinder_low_reg = 8'h00;
	logic [7:0] cylinder_high_reg = 8'h00, self_test_code = 8'h01;
	logic [15:0] host_wr_data = 16'h0000;
	logic busy, drq, cmd_done, irq, set_max_addr, retry_en, ecc_raw, host_wr_ready, host_rd_valid;
	logic media_rd_req, media_rd_valid, media_rd_ready, media_wr_req, media_wr_valid;
	logic media_wr_ready, pdiag_n_o, pdiag_n_oe, seen_irq, seen_set;
	logic [7:0] error_reg, tf_sector_count, tf_sector_number, tf_cylinder_low, tf_cylinder_high;
	logic [7:0] tf_device_head;
	logic [15:0] host_rd_data, media_rd_data, media_wr_data;
	logic [15:0] rd_prev = 16'h0000;
	wire logic pdiag_n_i;
	int errors = 0, comparisons = 0, wr_left = 0, rd_n = 0, media_wr_n;
	// pass line is pulled up; either device may pull it low
	assign pdiag_n_i = (pdiag_n_oe ? pdiag_n_o : 1'b1) & dev1_pass_n;
	alc_cmd #(.DIAG_WAIT_CYCLES(WAIT_CYC)) DUT (.sys_clk, .rst, .cmd_valid, .cmd_opcode,
		.features_reg, .sector_count_reg, .sector_number_reg, .cylinder_low_reg,
		.cylinder_high_reg, .device_head_reg, .busy, .drq, .cmd_done, .irq, .error_reg,
		.tf_sector_count, .tf_sector_number, .tf_cylinder_low, .tf_cylinder_high,
		.tf_device_head, .set_max_addr, .retry_en, .ecc_raw, .host_wr_valid, .host_wr_data,
		.host_wr_ready, .host_rd_valid, .host_rd_data, .host_rd_ready, .media_rd_req,
		.media_rd_valid, .media_rd_data, .media_rd_ready, .media_err, .media_wr_req,
		.media_wr_valid, .media_wr_data, .media_wr_ready, .self_test_code, .is_device1,
		.device1_present, .pdiag_n_i, .pdiag_n_o, .pdiag_n_oe);
	alc_media_model media (.sys_clk, .media_rd_req, .media_rd_ready, .media_rd_valid,
		.media_rd_data, .media_wr_valid, .media_wr_ready, .wr_count(media_wr_n));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// host word streams; valid only moves on the falling edge
	always @(posedge sys_clk) begin
		if (host_wr_valid && host_wr_ready) wr_left <= wr_left - 1;
		if (host_rd_valid && host_rd_ready) rd_n <= rd_n + 1;
	end
	always @(negedge sys_clk) host_wr_valid = (wr_left > 0);
	// raw words must pass unaltered both ways, with ecc handling off while they flow
	always @(posedge sys_clk) begin
		if (host_rd_valid && host_rd_ready) begin
			if (rd_n > 0) begin
				chk(host_rd_data, 16'(rd_prev + 16'h0001));
			end
			chk(ecc_raw, 1'b1);
			rd_prev <= host_rd_data;
		end
		if (media_wr_valid && media_wr_ready) begin
			chk({media_wr_data, ecc_raw}, {host_wr_data, 1'b1});
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
	endtask
	// one command, with nwr host words offered; waits for the done pulse
	task automatic run(input logic [7:0] op, f, dh, input int nwr, input logic [15:0] pw);
		int k;
		@(negedge sys_clk);
		wr_left = nwr;
		rd_n = 0;
		host_wr_data = pw;
		cmd_valid = 1'b1;
		cmd_opcode = op;
		features_reg = f;
		device_head_reg = dh;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		for (k = 0; k < 3000 && cmd_done !== 1'b1; k++) @(negedge sys_clk);
		seen_irq = irq;
		seen_set = set_max_addr;
		chk(cmd_done, 1'b1);
	endtask
	task automatic sub(input logic [7:0] f, input logic [15:0] pw, input logic [7:0] exp);
		// both password subcommands take a whole sector from the host
		run(OP_SET_MAX, f, 8'h00, (f == SUB_UNLOCK || f == SUB_SET_PASSWORD) ? 256 : 0, pw);
		chk(error_reg, exp);
	endtask
	task automatic protect();
		sub(SUB_FREEZE, 16'h0000, ERR_ABORT);
		sub(SUB_LOCK, 16'h0000, 8'h00);
		sub(SUB_SET_PASSWORD, 16'h0000, ERR_ABORT);
		repeat (5) sub(SUB_UNLOCK, 16'h5a5a, ERR_ABORT);
		sub(SUB_UNLOCK, 16'h0000, ERR_ABORT);
		sub(SUB_FREEZE, 16'h0000, 8'h00);
		sub(SUB_LOCK, 16'h0000, ERR_ABORT);
		sub(SUB_UNLOCK, 16'h0000, ERR_ABORT);
		do_reset();
		sub(SUB_SET_PASSWORD, 16'h5a5a, 8'h00);
		sub(SUB_LOCK, 16'h0000, 8'h00);
		sub(SUB_UNLOCK, 16'h5a5a, 8'h00);
		sub(SUB_SET_PASSWORD, 16'h0000, 8'h00);
	endtask
	task automatic native();
		run(OP_NATIVE_MAX, 8'h00, 8'h40, 0, 16'h0000);
		chk({tf_device_head[3:0], tf_cylinder_high, tf_cylinder_low, tf_sector_number},
			NATIVE_MAX_DEF);
		chk(seen_irq, 1'b1);
		run(OP_SET_MAX, SUB_LOCK, 8'h40, 0, 16'h0000);
		chk({seen_set, error_reg}, {1'b1, 8'h00});
	endtask
	task automatic diag(input logic d1p, pass, dev1, lba, input logic [7:0] code, err, sn,
		input logic exp_irq);
		@(negedge sys_clk);
		device1_present = d1p;
		dev1_pass_n = ~pass;
		is_device1 = dev1;
		self_test_code = code;
		repeat (3) @(negedge sys_clk);
		run(OP_DIAG, 8'h00, {1'b0, lba, 6'h10}, 0, 16'h0000);
		chk(error_reg, err);
		chk({tf_sector_count, tf_sector_number}, {TF_ONE, sn});
		chk(seen_irq, exp_irq);
	endtask
	task automatic long_cmds();
		int base;
		run(OP_READ_LONG, 8'h00, 8'h40, 0, 16'h0000);
		chk(rd_n, 32'(LONG_WORDS));
		chk({retry_en, tf_sector_count}, {1'b0, TF_ZERO});
		base = media_wr_n;
		run(OP_WRITE_LONG_RETRY, 8'h00, 8'h40, 258, 16'h1234);
		chk(media_wr_n - base, 32'(LONG_WORDS));
		chk(retry_en, 1'b1);
		fork
			run(OP_READ_LONG_RETRY, 8'h00, 8'h40, 0, 16'h0000);
			begin
				repeat (40) @(negedge sys_clk);
				media_err = 1'b1;
				@(negedge sys_clk);
				media_err = 1'b0;
			end
		join
		chk({tf_sector_count, error_reg}, {TF_ONE, ERR_ABORT});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge sys_clk);
		errors++;
		conclude();
	end
	initial begin
		do_reset();
		protect();
		native();
		diag(1'b0, 1'b0, 1'b0, 1'b0, DIAG_PASS, DIAG_PASS, TF_ONE, 1'b1);
		diag(1'b0, 1'b0, 1'b0, 1'b1, DIAG_BUF_ERR, DIAG_BUF_ERR, TF_ZERO, 1'b1);
		diag(1'b1, 1'b0, 1'b0, 1'b0, DIAG_ROM_ERR, 8'h85, TF_ONE, 1'b1);
		diag(1'b1, 1'b1, 1'b0, 1'b0, DIAG_PASS, DIAG_PASS, TF_ONE, 1'b1);
		diag(1'b0, 1'b0, 1'b1, 1'b0, DIAG_PASS, DIAG_PASS, TF_ONE, 1'b0);
		chk(pdiag_n_oe, 1'b1);
		long_cmds();
		conclude();
	end
endmodule // ata_max_lock_diag_long_cmds_tb_top

// ---- hw/alc_cmd.sv ----
/*
 * Command engine for maximum-address protection, native-maximum report,
 * device diagnostics and long sector read/write.
 * Assumes a task-file front end that presents each command as a one-cycle
 * pulse with the register values, and loads the result values on cmd_done.
 */
`timescale 1ns/1ps
module alc_cmd
	import alc_pkg::*;
#(
	parameter int unsigned DIAG_WAIT_CYCLES = DIAG_WAIT_CYC,
	parameter logic [27:0] NATIVE_MAX = NATIVE_MAX_DEF
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [7:0] features_reg,
	input wire logic [7:0] sector_count_reg,
	input wire logic [7:0] sector_number_reg,
	input wire logic [7:0] cylinder_low_reg,
	input wire logic [7:0] cylinder_high_reg,
	input wire logic [7:0] device_head_reg,
	output logic busy,
	output logic drq,
	output logic cmd_done,
	output logic irq,
	output logic [7:0] error_reg,
	output logic [7:0] tf_sector_count,
	output logic [7:0] tf_sector_number,
	output logic [7:0] tf_cylinder_low,
	output logic [7:0] tf_cylinder_high,
	output logic [7:0] tf_device_head,
	output logic set_max_addr,
	output logic retry_en,
	output logic ecc_raw,
	input wire logic host_wr_valid,
	input wire logic [15:0] host_wr_data,
	output logic host_wr_ready,
	output logic host_rd_valid,
	output logic [15:0] host_rd_data,
	input wire logic host_rd_ready,
	output logic media_rd_req,
	input wire logic media_rd_valid,
	input wire logic [15:0] media_rd_data,
	output logic media_rd_ready,
	input wire logic media_err,
	output logic media_wr_req,
	output logic media_wr_valid,
	output logic [15:0] media_wr_data,
	input wire logic media_wr_ready,
	input wire logic [7:0] self_test_code,
	input wire logic is_device1,
	input wire logic device1_present,
	input wire logic pdiag_n_i,
	output logic pdiag_n_o,
	output logic pdiag_n_oe
);

	alc_state_type state, next_state;
	alc_prot_type prot, next_prot;
	logic [2:0] unlock_cnt, next_unlock_cnt;
	logic native_ok, next_native_ok;
	logic [7:0] op, next_op;
	logic [7:0] feat, next_feat;
	logic irq_en, next_irq_en;
	logic aborted, next_aborted;
	logic [7:0] next_error_reg, next_sc, next_sn, next_cl, next_ch, next_dh;
	logic [8:0] word_cnt, next_word_cnt;
	logic mismatch, next_mismatch;
	logic [15:0] pwd [PWD_WORDS];
	logic [15:0] next_pwd [PWD_WORDS];
	logic next_host_rd_valid, next_media_wr_valid;
	logic [15:0] next_host_rd_data, next_media_wr_data;
	logic next_media_rd_req, next_media_wr_req, next_set_max_addr;
	logic [31:0] diag_cnt, next_diag_cnt;
	logic pdiag_drive, next_pdiag_drive;
	logic [2:0] pin_meta, pin_sync;
	logic pwd_win, word_miss, host_rd_take, media_wr_take;
	logic [3:0] pidx;

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end else begin
			pin_meta <= {~pdiag_n_i, device1_present, is_device1};
			pin_sync <= pin_meta;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// handshake terms and status decodes
	assign busy = (state != ST_IDLE);
	assign drq = (state == ST_SECT_IN) || (state == ST_RLONG) || (state == ST_WLONG);
	assign cmd_done = (state == ST_FINISH);
	assign irq = cmd_done && irq_en;
	// the rd stage empties or drains before it refills
	assign media_rd_ready = (state == ST_RLONG) && (!host_rd_valid || host_rd_ready);
	assign host_wr_ready = (state == ST_SECT_IN)
		|| ((state == ST_WLONG) && (!media_wr_valid || media_wr_ready));
	assign host_rd_take = host_rd_valid && host_rd_ready;
	assign media_wr_take = media_wr_valid && media_wr_ready;
	assign retry_en = ~op[0];
	assign ecc_raw = (state == ST_RLONG) || (state == ST_WLONG);
	assign pdiag_n_o = 1'b0;
	assign pdiag_n_oe = pdiag_drive;
	assign pwd_win = (word_cnt >= PWD_FIRST) && (word_cnt <= PWD_LAST);
	assign pidx = 4'(word_cnt - PWD_FIRST);
	assign word_miss = pwd_win && (host_wr_data != pwd[pidx]);

	//////////////////////////////////////////////////////////////////////////
	// command sequencing and protection state
	always_comb begin
		next_state = state;
		next_prot = prot;
		next_unlock_cnt = unlock_cnt;
		next_native_ok = native_ok;
		next_op = op;
		next_feat = feat;
		next_irq_en = irq_en;
		next_aborted = aborted;
		next_error_reg = error_reg;
		next_sc = tf_sector_count;
		next_sn = tf_sector_number;
		next_cl = tf_cylinder_low;
		next_ch = tf_cylinder_high;
		next_dh = tf_device_head;
		next_word_cnt = word_cnt;
		next_mismatch = mismatch;
		next_pwd = pwd;
		next_host_rd_valid = host_rd_valid;
		next_host_rd_data = host_rd_data;
		next_media_wr_valid = media_wr_valid;
		next_media_wr_data = media_wr_data;
		next_media_rd_req = 1'b0;
		next_media_wr_req = 1'b0;
		next_set_max_addr = 1'b0;
		next_diag_cnt = diag_cnt;
		next_pdiag_drive = pdiag_drive;
		case (state)
			ST_IDLE: begin
				if (cmd_valid) begin
					next_op = cmd_opcode;
					next_feat = features_reg;
					next_irq_en = 1'b1;
					next_aborted = 1'b0;
					next_error_reg = 8'h00;
					next_sc = sector_count_reg;
					next_sn = sector_number_reg;
					next_cl = cylinder_low_reg;
					next_ch = cylinder_high_reg;
					next_dh = device_head_reg;
					next_word_cnt = 9'h000;
					next_mismatch = 1'b0;
					next_native_ok = 1'b0;
					next_pdiag_drive = 1'b0;
					next_state = ST_FINISH;
					case (cmd_opcode)
						OP_NATIVE_MAX: begin
							next_state = ST_NATIVE;
						end
						OP_SET_MAX: begin
							if (native_ok) begin
								// any subcommand right after a native read sets the address when unlocked, else aborts
								if (prot == PROT_UNLOCKED) begin
									next_set_max_addr = 1'b1;
								end else begin
									next_aborted = 1'b1;
								end
							end else begin
								case (features_reg)
									SUB_SET_PASSWORD: begin
										if (prot == PROT_UNLOCKED) begin
											next_state = ST_SECT_IN;
										end else begin
											next_aborted = 1'b1;
										end
									end
									SUB_LOCK: begin
										if (prot == PROT_UNLOCKED) begin
											next_prot = PROT_LOCKED;
											next_unlock_cnt = UNLOCK_TRIES;
										end else begin
											next_aborted = 1'b1;
										end
									end
									SUB_UNLOCK: begin
										if (prot == PROT_FROZEN) begin
											next_aborted = 1'b1;
										end else if (prot == PROT_LOCKED && unlock_cnt == 3'h0) begin
											next_aborted = 1'b1;
										end else begin
											next_state = ST_SECT_IN;
										end
									end
									SUB_FREEZE: begin
										if (prot == PROT_UNLOCKED) begin
											next_aborted = 1'b1;
										end else begin
											next_prot = PROT_FROZEN;
										end
									end
									default: begin
										next_aborted = 1'b1;
									end
								endcase
							end
						end
						OP_DIAG: begin
							next_diag_cnt = 32'h0000_0000;
							next_state = ST_DIAG;
						end
						OP_READ_LONG_RETRY, OP_READ_LONG: begin
							next_media_rd_req = 1'b1;
							next_state = ST_RLONG;
						end
						OP_WRITE_LONG_RETRY, OP_WRITE_LONG: begin
							next_media_wr_req = 1'b1;
							next_state = ST_WLONG;
						end
						default: begin
							// not this block's command; it still ends a native read pairing
							next_state = ST_IDLE;
						end
					endcase
					if (next_aborted) begin
						next_error_reg = ERR_ABORT;
					end
				end
			end
			ST_NATIVE: begin
				next_dh = {tf_device_head[7:4], NATIVE_MAX[27:24]};
				next_ch = NATIVE_MAX[23:16];
				next_cl = NATIVE_MAX[15:8];
				next_sn = NATIVE_MAX[7:0];
				next_native_ok = 1'b1;
				next_state = ST_FINISH;
			end
			ST_SECT_IN: begin
				if (host_wr_valid) begin
					next_word_cnt = word_cnt + 9'h001;
					if (feat == SUB_SET_PASSWORD && pwd_win) begin
						next_pwd[pidx] = host_wr_data;
					end
					next_mismatch = mismatch || word_miss;
					if (word_cnt == SECTOR_WORDS - 9'h001) begin
						next_state = ST_FINISH;
						if (feat == SUB_UNLOCK && prot == PROT_LOCKED) begin
							if (mismatch || word_miss) begin
								next_aborted = 1'b1;
								next_error_reg = ERR_ABORT;
								next_unlock_cnt = unlock_cnt - 3'h1;
							end else begin
								next_prot = PROT_UNLOCKED;
							end
						end
					end
				end
			end
			ST_RLONG: begin
				if (host_rd_take) begin
					next_host_rd_valid = 1'b0;
					next_word_cnt = word_cnt + 9'h001;
				end
				if (media_rd_valid && media_rd_ready) begin
					next_host_rd_valid = 1'b1;
					next_host_rd_data = media_rd_data;
				end
				if (media_err) begin
					next_host_rd_valid = 1'b0;
					next_aborted = 1'b1;
					next_error_reg = ERR_ABORT;
					next_sc = TF_ONE;
					next_state = ST_FINISH;
				end else if (host_rd_take && word_cnt == LONG_WORDS - 9'h001) begin
					next_sc = TF_ZERO;
					next_state = ST_FINISH;
				end
			end
			ST_WLONG: begin
				if (media_wr_take) begin
					next_media_wr_valid = 1'b0;
					next_word_cnt = word_cnt + 9'h001;
				end
				if (host_wr_valid && host_wr_ready) begin
					next_media_wr_valid = 1'b1;
					next_media_wr_data = host_wr_data;
				end
				if (media_err) begin
					next_media_wr_valid = 1'b0;
					next_aborted = 1'b1;
					next_error_reg = ERR_ABORT;
					next_sc = TF_ONE;
					next_state = ST_FINISH;
				end else if (media_wr_take && word_cnt == LONG_WORDS - 9'h001) begin
					next_sc = TF_ZERO;
					next_state = ST_FINISH;
				end
			end
			ST_DIAG: begin
				// self_test_code carries DIAG_PASS, DIAG_BUF_ERR or DIAG_ROM_ERR
				next_sc = TF_ONE;
				next_sn = tf_device_head[DH_LBA_BIT] ? TF_ZERO : TF_ONE;
				next_error_reg = self_test_code;
				if (pin_sync[0]) begin
					next_pdiag_drive = (self_test_code == DIAG_PASS);
					next_irq_en = 1'b0;
					next_state = ST_FINISH;
				end else if (!pin_sync[1] || pin_sync[2]) begin
					next_state = ST_FINISH;
				end else if (diag_cnt >= DIAG_WAIT_CYCLES - 32'h1) begin
					next_error_reg = self_test_code | DIAG_DEV1_FAIL;
					next_state = ST_FINISH;
				end else begin
					next_diag_cnt = diag_cnt + 32'h1;
				end
			end
			ST_FINISH: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// power-up leaves protection open with full attempts and a blank password
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			prot <= PROT_UNLOCKED;
			unlock_cnt <= UNLOCK_TRIES;
			native_ok <= 1'b0;
			op <= 8'h00;
			feat <= 8'h00;
			irq_en <= 1'b0;
			aborted <= 1'b0;
			error_reg <= 8'h00;
			tf_sector_count <= 8'h00;
			tf_sector_number <= 8'h00;
			tf_cylinder_low <= 8'h00;
			tf_cylinder_high <= 8'h00;
			tf_device_head <= 8'h00;
			word_cnt <= 9'h000;
			mismatch <= 1'b0;
			for (int i = 0; i < PWD_WORDS; i++) begin
				pwd[i] <= 16'h0000;
			end
			host_rd_valid <= 1'b0;
			host_rd_data <= 16'h0000;
			media_wr_valid <= 1'b0;
			media_wr_data <= 16'h0000;
			media_rd_req <= 1'b0;
			media_wr_req <= 1'b0;
			set_max_addr <= 1'b0;
			diag_cnt <= 32'h0000_0000;
			pdiag_drive <= 1'b0;
		end else begin
			state <= next_state;
			prot <= next_prot;
			unlock_cnt <= next_unlock_cnt;
			native_ok <= next_native_ok;
			op <= next_op;
			feat <= next_feat;
			irq_en <= next_irq_en;
			aborted <= next_aborted;
			error_reg <= next_error_reg;
			tf_sector_count <= next_sc;
			tf_sector_number <= next_sn;
			tf_cylinder_low <= next_cl;
			tf_cylinder_high <= next_ch;
			tf_device_head <= next_dh;
			word_cnt <= next_word_cnt;
			mismatch <= next_mismatch;
			pwd <= next_pwd;
			host_rd_valid <= next_host_rd_valid;
			host_rd_data <= next_host_rd_data;
			media_wr_valid <= next_media_wr_valid;
			media_wr_data <= next_media_wr_data;
			media_rd_req <= next_media_rd_req;
			media_wr_req <= next_media_wr_req;
			set_max_addr <= next_set_max_addr;
			diag_cnt <= next_diag_cnt;
			pdiag_drive <= next_pdiag_drive;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// checks on the driven behaviour
	logic sm_cmd;
	assign sm_cmd = (state == ST_IDLE) && cmd_valid && (cmd_opcode == OP_SET_MAX) && !native_ok;

	property p_lock_enters;
		@(posedge sys_clk) disable iff (rst)
		(sm_cmd && features_reg == SUB_LOCK && prot == PROT_UNLOCKED)
		|=> (prot == PROT_LOCKED) && (unlock_cnt == 3'h5) && cmd_done && !aborted;
	endproperty
	a_lock_enters: assert property (p_lock_enters) else $error("lock not entered");

	property p_locked_rejects;
		@(posedge sys_clk) disable iff (rst)
		(sm_cmd && prot == PROT_LOCKED && features_reg == SUB_SET_PASSWORD)
		|=> cmd_done && aborted && error_reg == 8'h04 && prot == PROT_LOCKED;
	endproperty
	a_locked_rejects: assert property (p_locked_rejects) else $error("locked accepted");

	property p_mismatch;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_SECT_IN && host_wr_valid && word_cnt == 9'h0ff && feat == SUB_UNLOCK
			&& prot == PROT_LOCKED && (mismatch || word_miss))
		|=> aborted && prot == PROT_LOCKED && unlock_cnt == $past(unlock_cnt) - 3'h1;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch handling wrong");

	property p_exhausted;
		@(posedge sys_clk) disable iff (rst)
		(sm_cmd && features_reg == SUB_UNLOCK && prot == PROT_LOCKED && unlock_cnt == 3'h0)
		|=> cmd_done && aborted && !drq;
	endproperty
	a_exhausted: assert property (p_exhausted) else $error("exhausted unlock ran");

	property p_freeze_unlocked;
		@(posedge sys_clk) disable iff (rst)
		(sm_cmd && features_reg == SUB_FREEZE && prot == PROT_UNLOCKED)
		|=> aborted && prot == PROT_UNLOCKED;
	endproperty
	a_freeze_unlocked: assert property (p_freeze_unlocked) else $error("freeze accepted");

	property p_native_then_set;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_IDLE && cmd_valid && cmd_opcode == OP_SET_MAX && native_ok
			&& prot == PROT_UNLOCKED)
		|=> set_max_addr && cmd_done && prot == $past(prot);
	endproperty
	a_native_then_set: assert property (p_native_then_set) else $error("no set address");

	property p_native;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_IDLE && cmd_valid && cmd_opcode == OP_NATIVE_MAX)
		|=> busy ##1 irq && tf_sector_number == NATIVE_MAX[7:0]
			&& tf_cylinder_high == NATIVE_MAX[23:16] ##1 !busy;
	endproperty
	a_native: assert property (p_native) else $error("native report wrong");

	property p_dev1_silent;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_DIAG && pin_sync[0]) |=> cmd_done && !irq && tf_sector_count == 8'h01;
	endproperty
	a_dev1_silent: assert property (p_dev1_silent) else $error("device 1 interrupted");

	property p_long_ok;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_RLONG && !media_err && host_rd_take && word_cnt == 9'h101)
		|=> cmd_done && tf_sector_count == 8'h00 && !host_rd_valid;
	endproperty
	a_long_ok: assert property (p_long_ok) else $error("read long end wrong");

	property p_long_err;
		@(posedge sys_clk) disable iff (rst)
		((state == ST_RLONG || state == ST_WLONG) && media_err)
		|=> cmd_done && aborted && tf_sector_count == 8'h01;
	endproperty
	a_long_err: assert property (p_long_err) else $error("long error count wrong");

	c_unlock_ok: cover property (@(posedge sys_clk) disable iff (rst)
		(state == ST_SECT_IN && prot == PROT_LOCKED) ##[1:300] (prot == PROT_UNLOCKED));
	c_freeze: cover property (@(posedge sys_clk) disable iff (rst)
		(prot == PROT_LOCKED) ##[1:20] (prot == PROT_FROZEN));
	c_diag_timeout: cover property (@(posedge sys_clk) disable iff (rst)
		cmd_done && error_reg[7] && op == OP_DIAG);
	c_write_long: cover property (@(posedge sys_clk) disable iff (rst)
		state == ST_WLONG ##1 cmd_done && !aborted);

endmodule // alc_cmd

// ---- hw/alc_pkg.sv ----
/*
 * Shared constants for the maximum-address protection, native-maximum,
 * diagnostic and long read/write command logic of the drive controller.
 * Assumes a 250 MHz core clock and a 16-bit data word on all streams.
 */
package alc_pkg;
	// command opcodes
	localparam logic [7:0] OP_SET_MAX = 8'hf9;
	localparam logic [7:0] OP_NATIVE_MAX = 8'hf8;
	localparam logic [7:0] OP_DIAG = 8'h90;
	localparam logic [7:0] OP_READ_LONG_RETRY = 8'h22;
	localparam logic [7:0] OP_READ_LONG = 8'h23;
	localparam logic [7:0] OP_WRITE_LONG_RETRY = 8'h32;
	localparam logic [7:0] OP_WRITE_LONG = 8'h33;
	// maximum-address subcommands in the features register
	localparam logic [7:0] SUB_SET_PASSWORD = 8'h01;
	localparam logic [7:0] SUB_LOCK = 8'h02;
	localparam logic [7:0] SUB_UNLOCK = 8'h03;
	localparam logic [7:0] SUB_FREEZE = 8'h04;
	// unlock attempts loaded on lock and after reset
	localparam logic [2:0] UNLOCK_TRIES = 3'h5;
	// error register values
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam logic [7:0] DIAG_PASS = 8'h01;
	localparam logic [7:0] DIAG_BUF_ERR = 8'h03;
	localparam logic [7:0] DIAG_ROM_ERR = 8'h05;
	localparam logic [7:0] DIAG_DEV1_FAIL = 8'h80;
	// completion values of sector count and sector number
	localparam logic [7:0] TF_ONE = 8'h01;
	localparam logic [7:0] TF_ZERO = 8'h00;
	// field positions in the device/head register
	localparam int DH_LBA_BIT = 6;
	localparam int DH_SELECT_BIT = 4;
	// sector and password layout in 16-bit words
	localparam logic [8:0] SECTOR_WORDS = 9'h100;
	localparam logic [8:0] PWD_FIRST = 9'h001;
	localparam int PWD_WORDS = 16;
	localparam logic [8:0] PWD_LAST = 9'h010;
	// long transfers: one sector plus four ecc bytes, two words
	localparam logic [8:0] ECC_WORDS = 9'h002;
	localparam logic [8:0] LONG_WORDS = 9'h102;
	// device 0 waits this long for device 1 to pass
	localparam longint unsigned CLK_HZ = 250_000_000;
	localparam longint unsigned DIAG_WAIT_S = 5;
	localparam int unsigned DIAG_WAIT_CYC = 32'(DIAG_WAIT_S * CLK_HZ);
	// native maximum address default, a neutral value
	localparam logic [27:0] NATIVE_MAX_DEF = 28'h0ffffff;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_NATIVE = 7'h02,
		ST_SECT_IN = 7'h04,
		ST_RLONG = 7'h08,
		ST_WLONG = 7'h10,
		ST_DIAG = 7'h20,
		ST_FINISH = 7'h40
	} alc_state_type;

	typedef enum logic [2:0] {
		PROT_UNLOCKED = 3'h1,
		PROT_LOCKED = 3'h2,
		PROT_FROZEN = 3'h4
	} alc_prot_type;
endpackage
